/* File: hw/ebas_cycle_sel.sv */
`timescale 1ns/1ps
`default_nettype none
module ebas_cycle_sel import ebas_pkg::*; (
  input wire logic bus16,
  input wire logic is_fetch,
  input wire logic is_write,
  input wire logic len_flag,
  input wire logic addr_odd,
  output var ebas_cyc_e cyc_type,
  output logic two_phase
);
  always_comb begin
    cyc_type = EBAS_CYC_NONE;
    two_phase = 1'b0;
    if (is_fetch) begin
      if (bus16) begin
        cyc_type = addr_odd ? EBAS_CYC_G : EBAS_CYC_A;
      end else begin
        cyc_type = EBAS_CYC_I;
      end
    end else if (!len_flag) begin
      if (bus16) begin
        if (addr_odd) begin
          cyc_type = is_write ? EBAS_CYC_D : EBAS_CYC_C;
          two_phase = 1'b1;
        end else begin
          cyc_type = is_write ? EBAS_CYC_B : EBAS_CYC_A;
        end
      end else begin
        two_phase = 1'b1;
        if (is_write) begin
          cyc_type = addr_odd ? EBAS_CYC_K : EBAS_CYC_J;
        end else begin
          cyc_type = EBAS_CYC_I;
        end
      end
    end else begin
      if (bus16) begin
        if (addr_odd) begin
          cyc_type = is_write ? EBAS_CYC_H : EBAS_CYC_G;
        end else begin
          cyc_type = is_write ? EBAS_CYC_F : EBAS_CYC_E;
        end
      end else if (addr_odd) begin
        cyc_type = EBAS_CYC_K;
      end else begin
        cyc_type = is_write ? EBAS_CYC_J : EBAS_CYC_I;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/ebas_pkg.sv */
package ebas_pkg;
  typedef enum logic [3:0] {
    EBAS_CYC_A = 4'h0,
    EBAS_CYC_B = 4'h1,
    EBAS_CYC_C = 4'h2,
    EBAS_CYC_D = 4'h3,
    EBAS_CYC_E = 4'h4,
    EBAS_CYC_F = 4'h5,
    EBAS_CYC_G = 4'h6,
    EBAS_CYC_H = 4'h7,
    EBAS_CYC_I = 4'h8,
    EBAS_CYC_J = 4'h9,
    EBAS_CYC_K = 4'hA,
    EBAS_CYC_NONE = 4'hF
  } ebas_cyc_e;
  typedef enum logic [1:0] {
    EBAS_ST_IDLE = 2'b00,
    EBAS_ST_BUS = 2'b01,
    EBAS_ST_GAP = 2'b10
  } ebas_st_e;
endpackage

/* File: hw/ebas_regs.svh */
`ifndef EBAS_REGS_SVH
`define EBAS_REGS_SVH
`define EBAS_ADDR_W 24
`define EBAS_DATA_W 16
`define EBAS_RST_PC 24'h00_0000
`define EBAS_RST_DATA 16'h0000
`define EBAS_STEP_ONE 24'h00_0001
`define EBAS_STEP_TWO 24'h00_0002
`endif

/* File: hw/ebas_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ebas_regs.svh"
module ebas_sequencer import ebas_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic bus16_sel,
  input wire logic branch_valid,
  input wire logic [`EBAS_ADDR_W-1:0] branch_addr,
  input wire logic fetch_req,
  output logic fetch_ack,
  output logic [`EBAS_DATA_W-1:0] fetch_data,
  output logic [1:0] fetch_bytes,
  input wire logic data_req,
  input wire logic data_we,
  input wire logic data_len_flag,
  input wire logic [`EBAS_ADDR_W-1:0] data_addr,
  input wire logic [`EBAS_DATA_W-1:0] data_wdata,
  output logic data_ack,
  output logic [`EBAS_DATA_W-1:0] data_rdata,
  output logic [`EBAS_ADDR_W-1:0] ext_addr,
  output logic [`EBAS_DATA_W-1:0] ext_dout,
  output logic ext_dout_oe,
  input wire logic [`EBAS_DATA_W-1:0] ext_din,
  input wire logic ext_rdy,
  output logic ext_rd_n,
  output logic ext_wr_n,
  output logic ext_ble_n,
  output logic ext_bhe_n,
  output logic [3:0] cyc_type,
  output logic cyc_half
);
  // odd bytes travel on the high lane only when the bus is 16 bits wide
  function automatic logic ebas_hi_lane(input logic addr0, input logic b16);
    return addr0 & b16;
  endfunction

  ebas_st_e st_q, st_d;
  ebas_cyc_e typ_q, typ_d, sel_typ;
  logic [`EBAS_ADDR_W-1:0] addr_q, addr_d, pc_q, pc_d, cur_addr, sel_addr;
  logic [`EBAS_DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic we_q, we_d, fetch_q, fetch_d, two_q, two_d, both_q, both_d, half_q, half_d;
  logic fack_q, fack_d, dack_q, dack_d;
  logic data_go, fetch_go, go, sel_fetch, sel_two, done_phase, hi;
  logic [7:0] rd_byte, wr_byte;

  assign data_go = data_req && !dack_q;
  assign fetch_go = fetch_req && !fack_q;
  assign go = data_go || fetch_go;
  // data waits less on the CPU than a queue top-up, so it goes first
  assign sel_fetch = !data_go;
  assign sel_addr = sel_fetch ? pc_q : data_addr;

  // width and operand length are separate ports; neither is derived from the other
  ebas_cycle_sel u_sel (
    .bus16(bus16_sel),
    .is_fetch(sel_fetch),
    .is_write(data_we && !sel_fetch),
    .len_flag(data_len_flag),
    .addr_odd(sel_addr[0]),
    .cyc_type(sel_typ),
    .two_phase(sel_two)
  );

  assign cur_addr = addr_q + {{(`EBAS_ADDR_W-1){1'b0}}, half_q};
  assign hi = ebas_hi_lane(cur_addr[0], bus16_sel);
  assign done_phase = (st_q == EBAS_ST_BUS) && ext_rdy;
  assign rd_byte = hi ? ext_din[15:8] : ext_din[7:0];
  assign wr_byte = half_q ? wdata_q[15:8] : wdata_q[7:0];

  always_comb begin
    st_d = st_q;
    typ_d = typ_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    we_d = we_q;
    fetch_d = fetch_q;
    two_d = two_q;
    both_d = both_q;
    half_d = half_q;
    pc_d = pc_q;
    fack_d = 1'b0;
    dack_d = 1'b0;
    case (st_q)
      EBAS_ST_IDLE: begin
        if (go) begin
          st_d = EBAS_ST_BUS;
          typ_d = sel_typ;
          addr_d = sel_addr;
          wdata_d = data_wdata;
          we_d = data_we && !sel_fetch;
          fetch_d = sel_fetch;
          two_d = sel_two;
          // one cycle carries both lanes only for an aligned word on a wide bus
          both_d = bus16_sel && !sel_addr[0] && (sel_fetch || !data_len_flag);
          half_d = 1'b0;
        end
      end
      EBAS_ST_BUS: begin
        if (ext_rdy) begin
          if (both_q) begin
            rdata_d = ext_din;
          end else if (half_q) begin
            rdata_d[15:8] = rd_byte;
          end else begin
            rdata_d = {8'h00, rd_byte};
          end
          if (two_q && !half_q) begin
            st_d = EBAS_ST_GAP;
          end else begin
            st_d = EBAS_ST_IDLE;
            fack_d = fetch_q;
            dack_d = !fetch_q;
            // a fetch overtaken by a branch must not move the new pointer
            if (fetch_q && pc_q == addr_q) begin
              // an odd fetch leaves the pointer even, so on a wide bus word fetches follow
              pc_d = pc_q + (both_q ? `EBAS_STEP_TWO : `EBAS_STEP_ONE);
            end
          end
        end
      end
      EBAS_ST_GAP: begin
        st_d = EBAS_ST_BUS;
        half_d = 1'b1;
      end
      default: begin
        st_d = EBAS_ST_IDLE;
      end
    endcase
    // a branch always wins the pointer; a fetch in flight still completes
    if (branch_valid) begin
      pc_d = branch_addr;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= EBAS_ST_IDLE;
      typ_q <= EBAS_CYC_NONE;
      addr_q <= `EBAS_RST_PC;
      pc_q <= `EBAS_RST_PC;
      wdata_q <= `EBAS_RST_DATA;
      rdata_q <= `EBAS_RST_DATA;
      we_q <= 1'b0;
      fetch_q <= 1'b0;
      two_q <= 1'b0;
      both_q <= 1'b0;
      half_q <= 1'b0;
      fack_q <= 1'b0;
      dack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      typ_q <= typ_d;
      addr_q <= addr_d;
      pc_q <= pc_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      we_q <= we_d;
      fetch_q <= fetch_d;
      two_q <= two_d;
      both_q <= both_d;
      half_q <= half_d;
      fack_q <= fack_d;
      dack_q <= dack_d;
    end
  end

  // bus pins decode from flops and bus16_sel; bus16_sel reaches the byte enables through hi, no other input reaches them
  always_comb begin
    ext_addr = cur_addr;
    ext_rd_n = !((st_q == EBAS_ST_BUS) && !we_q);
    ext_wr_n = !((st_q == EBAS_ST_BUS) && we_q);
    ext_dout_oe = (st_q == EBAS_ST_BUS) && we_q;
    ext_dout = both_q ? wdata_q : {wr_byte, wr_byte};
    ext_ble_n = !((st_q == EBAS_ST_BUS) && (both_q || !hi));
    ext_bhe_n = !((st_q == EBAS_ST_BUS) && (both_q || hi));
  end

  assign fetch_ack = fack_q;
  assign data_ack = dack_q;
  assign fetch_data = rdata_q;
  assign data_rdata = rdata_q;
  assign fetch_bytes = both_q ? 2'd2 : 2'd1;
  assign cyc_type = typ_q;
  assign cyc_half = half_q;

  wire launch = (st_q == EBAS_ST_IDLE) && go;

  sequence s_odd_fetch_end;
    done_phase && fetch_q && !both_q && bus16_sel && !branch_valid && pc_q == addr_q;
  endsequence
  sequence s_first_half_end;
    done_phase && two_q && !half_q;
  endsequence

  chk_fetch_even_word: assert property (@(posedge mclk) disable iff (!arst_n)
    launch && sel_fetch && bus16_sel && !pc_q[0] |=> typ_q == EBAS_CYC_A && !ext_ble_n && !ext_bhe_n)
    else $error("even fetch on wide bus not a type a word");
  chk_fetch_narrow_byte: assert property (@(posedge mclk) disable iff (!arst_n)
    launch && sel_fetch && !bus16_sel |=> typ_q == EBAS_CYC_I && !two_q && ext_bhe_n)
    else $error("narrow bus fetch not a single first half byte");
  chk_fetch_odd_byte: assert property (@(posedge mclk) disable iff (!arst_n)
    launch && sel_fetch && bus16_sel && pc_q[0] |=> typ_q == EBAS_CYC_G && !ext_bhe_n && ext_ble_n)
    else $error("odd fetch on wide bus not a type g byte");
  chk_branch_odd_align: assert property (@(posedge mclk) disable iff (!arst_n)
    s_odd_fetch_end |=> !pc_q[0] && fack_q && fetch_bytes == 2'd1)
    else $error("odd fetch did not realign the pointer");
  chk_word_even_type: assert property (@(posedge mclk) disable iff (!arst_n)
    launch && !sel_fetch && !data_len_flag && !data_addr[0]
    |=> typ_q inside {EBAS_CYC_A, EBAS_CYC_B, EBAS_CYC_I, EBAS_CYC_J})
    else $error("even word access used a wrong cycle type");
  chk_word_odd_type: assert property (@(posedge mclk) disable iff (!arst_n)
    launch && !sel_fetch && !data_len_flag && data_addr[0]
    |=> typ_q inside {EBAS_CYC_C, EBAS_CYC_D, EBAS_CYC_I, EBAS_CYC_K} && two_q)
    else $error("odd word access used a wrong cycle type");
  chk_byte_even_type: assert property (@(posedge mclk) disable iff (!arst_n)
    launch && !sel_fetch && data_len_flag && !data_addr[0]
    |=> typ_q inside {EBAS_CYC_E, EBAS_CYC_F, EBAS_CYC_I, EBAS_CYC_J} && !two_q)
    else $error("even byte access used a wrong cycle type");
  chk_byte_odd_type: assert property (@(posedge mclk) disable iff (!arst_n)
    launch && !sel_fetch && data_len_flag && data_addr[0]
    |=> typ_q inside {EBAS_CYC_G, EBAS_CYC_H, EBAS_CYC_K} && !two_q)
    else $error("odd byte access used a wrong cycle type");
  chk_flag_sets_length: assert property (@(posedge mclk) disable iff (!arst_n)
    launch && !sel_fetch && !bus16_sel |=> two_q == !$past(data_len_flag))
    else $error("length flag did not choose the access length");
  chk_two_half_walk: assert property (@(posedge mclk) disable iff (!arst_n)
    s_first_half_end |=> st_q == EBAS_ST_GAP && ext_rd_n && ext_wr_n ##1 st_q == EBAS_ST_BUS && half_q)
    else $error("second half of a split access did not follow");
endmodule
`default_nettype wire

/* File: verif/ebas_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ebas_mem_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic bus16_sel,
  input wire logic slow,
  input wire logic [23:0] ext_addr,
  input wire logic [15:0] ext_dout,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire logic ext_ble_n,
  input wire logic ext_bhe_n,
  output var logic [15:0] ext_din,
  output logic ext_rdy
);
  logic [7:0] mem [0:255];
  logic [1:0] cnt_q;
  logic [15:0] last_q;
  logic [7:0] a;
  logic act;
  assign a = ext_addr[7:0];
  assign act = !ext_rd_n || !ext_wr_n;
  // slow mode stalls each phase two cycles
  assign ext_rdy = act && (cnt_q == (slow ? 2'd2 : 2'd0));
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
  end
  // released bus shows a toggling pattern, never a stale value
  always @* begin
    if (!ext_rd_n) begin
      ext_din = bus16_sel ? {mem[{a[7:1], 1'b1}], mem[{a[7:1], 1'b0}]} : {~last_q[15:8], mem[a]};
    end else begin
      ext_din = ~last_q;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 2'd0;
      last_q <= 16'h0000;
    end else begin
      cnt_q <= (act && !ext_rdy) ? cnt_q + 2'd1 : 2'd0;
      last_q <= ext_din;
    end
  end
  always @(posedge mclk) begin
    if (!ext_wr_n && ext_rdy) begin
      if (!bus16_sel) begin
        mem[a] <= ext_dout[7:0];
      end else begin
        if (!ext_ble_n) mem[{a[7:1], 1'b0}] <= ext_dout[7:0];
        if (!ext_bhe_n) mem[{a[7:1], 1'b1}] <= ext_dout[15:8];
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb import ebas_pkg::*;;
  logic mclk = 0, arst_n = 0, bus16_sel = 1, branch_valid = 0, fetch_req = 0, slow = 0;
  logic data_req = 0, data_we = 0, data_len_flag = 0, act_p, fh;
  logic [23:0] branch_addr = 0, data_addr = 0, ext_addr;
  logic [15:0] data_wdata = 0, fetch_data, data_rdata, ext_dout, ext_din;
  logic fetch_ack, data_ack, ext_dout_oe, ext_rdy, ext_rd_n, ext_wr_n, ext_ble_n, ext_bhe_n, cyc_half;
  logic [1:0] fetch_bytes;
  logic [3:0] cyc_type, ft;
  int miscompares = 0, checked = 0, ph = 0;
  ebas_sequencer u_dut (
    .mclk(mclk),
    .arst_n(arst_n),
    .bus16_sel(bus16_sel),
    .branch_valid(branch_valid),
    .branch_addr(branch_addr),
    .fetch_req(fetch_req),
    .fetch_ack(fetch_ack),
    .fetch_data(fetch_data),
    .fetch_bytes(fetch_bytes),
    .data_req(data_req),
    .data_we(data_we),
    .data_len_flag(data_len_flag),
    .data_addr(data_addr),
    .data_wdata(data_wdata),
    .data_ack(data_ack),
    .data_rdata(data_rdata),
    .ext_addr(ext_addr),
    .ext_dout(ext_dout),
    .ext_dout_oe(ext_dout_oe),
    .ext_din(ext_din),
    .ext_rdy(ext_rdy),
    .ext_rd_n(ext_rd_n),
    .ext_wr_n(ext_wr_n),
    .ext_ble_n(ext_ble_n),
    .ext_bhe_n(ext_bhe_n),
    .cyc_type(cyc_type),
    .cyc_half(cyc_half)
  );
  ebas_mem_model u_mem (
    .mclk(mclk),
    .arst_n(arst_n),
    .bus16_sel(bus16_sel),
    .slow(slow),
    .ext_addr(ext_addr),
    .ext_dout(ext_dout),
    .ext_rd_n(ext_rd_n),
    .ext_wr_n(ext_wr_n),
    .ext_ble_n(ext_ble_n),
    .ext_bhe_n(ext_bhe_n),
    .ext_din(ext_din),
    .ext_rdy(ext_rdy)
  );
  always #5 mclk = ~mclk;
  // record type and half of the first phase of each access
  always @(posedge mclk) begin
    act_p <= !ext_rd_n || !ext_wr_n;
    if ((!ext_rd_n || !ext_wr_n) && !act_p) begin
      ph++;
      if (ph == 1) begin
        ft = cyc_type;
        fh = cyc_half;
      end
    end
  end
  function automatic logic [7:0] pat(input logic [23:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction
  function automatic ebas_cyc_e exp_cyc(input logic b, w, f, o);
    if (b) return f ? (o ? (w ? EBAS_CYC_H : EBAS_CYC_G) : (w ? EBAS_CYC_F : EBAS_CYC_E))
                    : (o ? (w ? EBAS_CYC_D : EBAS_CYC_C) : (w ? EBAS_CYC_B : EBAS_CYC_A));
    if (!w) return (f && o) ? EBAS_CYC_K : EBAS_CYC_I;
    return o ? EBAS_CYC_K : EBAS_CYC_J;
  endfunction
  // fe selects which acknowledge to wait for
  task automatic wack(input logic fe);
    int n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((fe ? fetch_ack : data_ack) !== 1'b1 && n < 50);
    if ((fe ? fetch_ack : data_ack) !== 1'b1) miscompares++;
  endtask
  task automatic branch(input logic [23:0] a);
    @(posedge mclk);
    branch_valid <= 1;
    branch_addr <= a;
    @(posedge mclk);
    branch_valid <= 0;
  endtask
  task automatic fchk(input logic [23:0] a, input logic [1:0] nb, input logic [3:0] ty);
    @(posedge mclk);
    ph = 0;
    // no stale type from an earlier access may pass
    ft = 4'hE;
    fetch_req <= 1;
    wack(1'b1);
    fetch_req <= 0;
    `CHK(fetch_data, (nb == 2'd2) ? {pat(a + 24'h1), pat(a)} : {8'h00, pat(a)})
    `CHK(fetch_bytes, nb)
    `CHK(ft, ty)
    `CHK(fh, 1'b0)
  endtask
  task automatic acc(input logic w, f, input logic [23:0] a, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge mclk);
    ph = 0;
    ft = 4'hE;
    data_req <= 1;
    data_we <= w;
    data_len_flag <= f;
    data_addr <= a;
    data_wdata <= wd;
    wack(1'b0);
    data_req <= 0;
    rd = data_rdata;
  endtask
  task automatic t_reset;
    @(posedge mclk);
    `CHK(cyc_type, 4'hF)
    `CHK({ext_rd_n, ext_wr_n, ext_ble_n, ext_bhe_n, ext_dout_oe}, 5'b11110)
    `CHK(fetch_bytes, 2'd1)
  endtask
  task automatic t_fetch;
    branch(24'h00_0010);
    fchk(24'h00_0010, 2'd2, EBAS_CYC_A);
    branch(24'h00_0021);
    fchk(24'h00_0021, 2'd1, EBAS_CYC_G);
    fchk(24'h00_0022, 2'd2, EBAS_CYC_A);
    bus16_sel <= 0;
    branch(24'h00_0030);
    fchk(24'h00_0030, 2'd1, EBAS_CYC_I);
    fchk(24'h00_0031, 2'd1, EBAS_CYC_I);
  endtask
  // every width, length, direction and alignment; odd cases stall
  task automatic t_data;
    logic [15:0] wd, rd;
    logic [23:0] a;
    for (int i = 0; i < 8; i++) begin
      bus16_sel <= i[2];
      slow <= i[0];
      a = 24'h00_0040 + 24'(i * 4) + 24'(i[0]);
      wd = {8'hC0 + 8'(i), 8'h30 + 8'(i)};
      acc(1'b1, i[1], a, wd, rd);
      `CHK(ft, 4'(exp_cyc(i[2], 1'b1, i[1], i[0])))
      `CHK(ph, (!i[1] && (!i[2] || i[0])) ? 2 : 1)
      `CHK(u_mem.mem[a[7:0]], wd[7:0])
      acc(1'b0, i[1], a, 16'h0000, rd);
      `CHK(ft, 4'(exp_cyc(i[2], 1'b0, i[1], i[0])))
      `CHK(fh, 1'b0)
      `CHK(rd, i[1] ? {8'h00, wd[7:0]} : wd)
    end
  endtask
  task automatic end_of_test;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1;
    t_reset;
    t_fetch;
    t_data;
    end_of_test;
  end
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
endmodule
`default_nettype wire
